// file: hw/pfg_pkg.sv
package pfg_pkg;

	localparam logic [11:0] CTRL_OFFSET = 12'h808;
	localparam logic [11:0] CDN_OFFSET  = 12'h810;

	localparam int EN_BIT      = 31;
	localparam int RESTART_BIT = 30;
	localparam int MV_BIT      = 12;
	localparam int AV_BIT      = 11;
	localparam int PN_BIT      = 10;
	localparam int ER_BIT      = 9;
	localparam int CI_BIT      = 8;
	localparam int CE_HI       = 7;
	localparam int CE_LO       = 6;
	localparam int DE_BIT      = 5;
	localparam int UEO_BIT     = 4;
	localparam int UER_BIT     = 3;
	localparam int UEU_BIT     = 2;
	localparam int UC_BIT      = 1;
	localparam int OF_BIT      = 0;
	localparam int CDN_MSB     = 31;

	localparam logic [63:0] CTRL_DEFINED  = 64'h0000_0000_c000_1fff;
	localparam logic [63:0] RAO_POSSIBLE  = 64'h0000_0000_0000_1800;
	localparam logic [63:0] CTRL_RESET    = 64'h0;
	localparam logic [31:0] CDN_RESET     = 32'h0;
	localparam logic [31:0] CNT_ZERO      = 32'h0;
	localparam logic [31:0] CNT_ONE       = 32'h1;
	localparam logic [1:0]  INJ_ABSENT    = 2'h0;

	typedef enum logic [2:0] {
		KIND_NONE = 3'h0,
		KIND_UC   = 3'h1,
		KIND_UEU  = 3'h2,
		KIND_UER  = 3'h3,
		KIND_UEO  = 3'h4,
		KIND_DE   = 3'h5,
		KIND_CE   = 3'h6
	} inject_kind_t;

endpackage

// file: hw/pseudo_fault_counter.sv
`timescale 1ns/10ps
module pseudo_fault_counter
	import pfg_pkg::*;
#(
	parameter logic [1:0]  INJ_FEATURE  = 2'h1,
	parameter bit          FIRST_RECORD = 1'b1,
	parameter logic [63:0] SUPPORT_MASK = CTRL_DEFINED,
	parameter logic [63:0] ALWAYS_ONE   = 64'h0,
	parameter int          TICK_DIV     = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	input  wire logic         errRecoveryRst_n,
	input  wire logic         regWrite,
	input  wire logic         regRead,
	input  wire logic [11:0]  regAddr,
	input  wire logic [63:0]  regWdata,
	output logic      [63:0]  regRdata,
	output logic              regReadValid,
	output logic              injectValid,
	output inject_kind_t      injectKind,
	output logic      [1:0]   injectCe,
	output logic              injectMv,
	output logic              injectAv,
	output logic              injectPn,
	output logic              injectEr,
	output logic              injectCi,
	output logic              injectOf
);

	// ------------------------------------------------------------
	// Register presence and field masks
	// ------------------------------------------------------------
	logic         present;
	logic [63:0]  implMask;
	logic [63:0]  raoMask;
	logic [63:0]  ctrl;
	logic [63:0]  ctrlView;
	logic [31:0]  countdown_value;
	logic [31:0]  cnt;
	logic [15:0]  tickCnt;
	logic         tick;
	logic         ctrlWrite;
	logic         loadPulse;
	logic         decrement;
	logic         reachZero;
	inject_kind_t next_kind;

	assign present  = (INJ_FEATURE != INJ_ABSENT) && FIRST_RECORD;
	assign implMask = present ? ((SUPPORT_MASK & CTRL_DEFINED) | (64'h1 << EN_BIT)) : 64'h0;
	assign raoMask  = present ? (ALWAYS_ONE & RAO_POSSIBLE) : 64'h0;
	assign ctrlView = (ctrl & implMask) | raoMask;

	assign ctrlWrite = regWrite && present && (regAddr == CTRL_OFFSET);

	// ------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------
	// Unknown-at-reset fields are cleared anyway so simulation starts clean.
	// reset behaviour
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= CTRL_RESET;
		end else if (ctrlWrite) begin
			ctrl <= regWdata & implMask;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			countdown_value <= CDN_RESET;
		end else if (regWrite && present && (regAddr == CDN_OFFSET)) begin
			countdown_value <= regWdata[CDN_MSB:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			regRdata     <= 64'h0;
			regReadValid <= 1'b0;
		end else begin
			regReadValid <= regRead;
			if (!regRead || !present) begin
				regRdata <= 64'h0;
			end else if (regAddr == CTRL_OFFSET) begin
				regRdata <= ctrlView;
			end else if (regAddr == CDN_OFFSET) begin
				regRdata <= {32'h0, countdown_value};
			end else begin
				regRdata <= 64'h0;
			end
		end
	end

	// ------------------------------------------------------------
	// Error generation counter
	// ------------------------------------------------------------
	// The prescaler restarts on every load so the first step is a full tick away.
	// The prescaler is sixteen bits wide, so TICK_DIV must not exceed 65536.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tickCnt <= 16'h0;
		end else if (loadPulse || tick) begin
			tickCnt <= 16'h0;
		end else begin
			tickCnt <= tickCnt + 16'h1;
		end
	end
	assign tick = (tickCnt == 16'(TICK_DIV - 1));

	assign loadPulse = ctrlWrite && regWdata[EN_BIT];
	assign decrement = ctrlView[EN_BIT] && (cnt != CNT_ZERO) && tick && !loadPulse && errRecoveryRst_n;
	assign reachZero = decrement && (cnt == CNT_ONE);

	// Error recovery empties the counter; software must re-enable to resume.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= CNT_ZERO;
		end else if (!errRecoveryRst_n) begin
			cnt <= CNT_ZERO;
		end else if (loadPulse) begin
			cnt <= countdown_value;
		end else if (reachZero) begin
			cnt <= ctrlView[RESTART_BIT] ? countdown_value : CNT_ZERO;
		end else if (decrement) begin
			cnt <= cnt - CNT_ONE;
		end
	end

	// ------------------------------------------------------------
	// Injected error selection
	// ------------------------------------------------------------
	// Most severe enabled type wins so at most one is raised per expiry.
	// pick one type
	always_comb begin
		if (ctrlView[UC_BIT]) begin
			next_kind = KIND_UC;
		end else if (ctrlView[UEU_BIT]) begin
			next_kind = KIND_UEU;
		end else if (ctrlView[UER_BIT]) begin
			next_kind = KIND_UER;
		end else if (ctrlView[UEO_BIT]) begin
			next_kind = KIND_UEO;
		end else if (ctrlView[DE_BIT]) begin
			next_kind = KIND_DE;
		end else if (ctrlView[CE_HI:CE_LO] != 2'h0) begin
			next_kind = KIND_CE;
		end else begin
			next_kind = KIND_NONE;
		end
	end

	// Kind and flags hold between expiries so a slow recorder can still pick them up.
	// flag copy
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			injectValid <= 1'b0;
			injectKind  <= KIND_NONE;
			injectCe    <= 2'h0;
			injectMv    <= 1'b0;
			injectAv    <= 1'b0;
			injectPn    <= 1'b0;
			injectEr    <= 1'b0;
			injectCi    <= 1'b0;
			injectOf    <= 1'b0;
		end else begin
			injectValid <= reachZero && (next_kind != KIND_NONE);
			if (reachZero) begin
				injectKind <= next_kind;
				injectCe   <= (next_kind == KIND_CE) ? ctrlView[CE_HI:CE_LO] : 2'h0;
				injectMv   <= ctrlView[MV_BIT];
				injectAv   <= ctrlView[AV_BIT];
				injectPn   <= ctrlView[PN_BIT];
				injectEr   <= ctrlView[ER_BIT];
				injectCi   <= ctrlView[CI_BIT];
				injectOf   <= ctrlView[OF_BIT];
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_load_counter: assert property (@(posedge clk_sys) disable iff (!rst_n)
		loadPulse && errRecoveryRst_n |=> cnt == $past(countdown_value))
		else $error("Counter not loaded from countdown value.");

	chk_decrement_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
		decrement && !reachZero |=> cnt == $past(cnt) - CNT_ONE)
		else $error("Counter did not step down by one.");

	chk_zero_inject: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reachZero && next_kind != KIND_NONE |=> injectValid && injectKind == $past(next_kind))
		else $error("Expiry did not raise the selected error.");

	chk_restart_reload: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reachZero && ctrlView[RESTART_BIT] |=> cnt == $past(countdown_value))
		else $error("Counter did not reload on restart.");

	chk_stop_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cnt == CNT_ZERO && !loadPulse |=> cnt == CNT_ZERO [*2] or loadPulse)
		else $error("Stopped counter moved without a load.");

	chk_disabled_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!ctrlView[EN_BIT] |=> !injectValid)
		else $error("Injection while counter disabled.");

	chk_cold_enable: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!$past(rst_n) |-> !ctrl[EN_BIT] && cnt == CNT_ZERO)
		else $error("Enable not clear after cold reset.");

	chk_recovery_keep: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!errRecoveryRst_n && !regWrite |=> ctrl == $past(ctrl) && countdown_value == $past(countdown_value))
		else $error("Controls lost over error-recovery reset.");

	chk_readback_hidden: assert property (@(posedge clk_sys) disable iff (!rst_n)
		regRead && present && regAddr == CDN_OFFSET |=> regReadValid && regRdata == {32'h0, $past(countdown_value)})
		else $error("Countdown read did not return reload value.");

	chk_flag_copy: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reachZero |=> {injectMv, injectAv, injectPn, injectEr, injectCi} == $past(ctrlView[MV_BIT:CI_BIT]))
		else $error("Record flags differ from control bits.");

	chk_ctrl_masks: assert property (@(posedge clk_sys) disable iff (!rst_n)
		regRead && regAddr == CTRL_OFFSET |=> (regRdata & ~(implMask | raoMask)) == 64'h0
			&& (regRdata & raoMask) == raoMask)
		else $error("Control read shows unsupported or missing forced bits.");

	chk_single_shot: assert property (@(posedge clk_sys) disable iff (!rst_n)
		injectValid |-> $past(cnt) == CNT_ONE && $past(decrement))
		else $error("Injection without a counter expiry.");

	// These checks look one edge past the expiry, where the registered outputs have settled.
	chk_stop_after_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reachZero && !ctrlView[RESTART_BIT] |=> cnt == CNT_ZERO)
		else $error("Counter did not stop at zero.");

	// Looking at the earlier restart setting keeps a late write to that bit from tripping this.
	chk_no_repeat: assert property (@(posedge clk_sys) disable iff (!rst_n)
		injectValid && !$past(ctrlView[RESTART_BIT]) |=> !injectValid)
		else $error("Second injection without a new enable write.");

	chk_disabled_frozen: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!ctrlView[EN_BIT] && !loadPulse && errRecoveryRst_n |=> cnt == $past(cnt))
		else $error("Disabled counter kept moving.");

	chk_kind_priority: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reachZero && ctrlView[UC_BIT] |=> injectKind == KIND_UC)
		else $error("Most severe enabled type not chosen.");

	chk_kind_none: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reachZero && ctrlView[CE_HI:UC_BIT] == 7'h0 |=> !injectValid)
		else $error("Injection with no error type enabled.");

	chk_ce_selected: assert property (@(posedge clk_sys) disable iff (!rst_n)
		injectValid && injectKind == KIND_CE |-> injectCe != 2'h0)
		else $error("Corrected error raised without a type code.");

	chk_ce_only_ce: assert property (@(posedge clk_sys) disable iff (!rst_n)
		injectValid && injectKind != KIND_CE |-> injectCe == 2'h0)
		else $error("Corrected type code shown for another error type.");

	chk_forced_flags: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reachZero |=> (injectMv || !raoMask[MV_BIT]) && (injectAv || !raoMask[AV_BIT]))
		else $error("Forced record flag not set on injection.");

	// ------------------------------------------------------------
	// Register checks
	// ------------------------------------------------------------
	// A recovery reset leaves software state alone; only the hidden counter is emptied.
	chk_recovery_enable: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!errRecoveryRst_n && !ctrlWrite |=> ctrlView[EN_BIT] == $past(ctrlView[EN_BIT]))
		else $error("Enable lost over error-recovery reset.");

	chk_cold_outputs: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!$past(rst_n) |-> !injectValid && !regReadValid && regRdata == 64'h0)
		else $error("Outputs not quiet after cold reset.");

	chk_cdn_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		regWrite && present && regAddr == CDN_OFFSET |=> countdown_value == $past(regWdata[CDN_MSB:0]))
		else $error("Countdown write did not land.");

	chk_read_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
		regReadValid |-> $past(regRead))
		else $error("Read data flagged without a read.");

	// A write in the same cycle as a read must not leak into the returned word.
	chk_ctrl_readback: assert property (@(posedge clk_sys) disable iff (!rst_n)
		regRead && present && regAddr == CTRL_OFFSET |=> regRdata == $past(ctrlView))
		else $error("Control read differs from the masked control word.");

	chk_absent_reads: assert property (@(posedge clk_sys) disable iff (!rst_n)
		regRead && !present |=> regRdata == 64'h0)
		else $error("Absent registers did not read as zero.");

	chk_unmapped_reads: assert property (@(posedge clk_sys) disable iff (!rst_n)
		regRead && regAddr != CTRL_OFFSET && regAddr != CDN_OFFSET |=> regRdata == 64'h0)
		else $error("Unmapped offset did not read as zero.");

endmodule // pseudo_fault_counter

// file: test/pseudo_fault_injection_counter_bench.sv
`timescale 1ns/10ps
module pseudo_fault_injection_counter_bench import pfg_pkg::*;;
	`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin failures++; $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end

	// ----------------------------------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------------------------------
	logic         clk_sys          = 1'b0;
	logic         rst_n            = 1'b0;
	logic         errRecoveryRst_n = 1'b1;
	logic         regWrite         = 1'b0;
	logic         regRead          = 1'b0;
	logic [11:0]  regAddr          = 12'h0;
	logic [63:0]  regWdata         = 64'h0;
	logic [63:0]  rdA, rdB, rdC;
	logic         rvA;
	logic         injectValid;
	inject_kind_t injectKind;
	logic [1:0]   injectCe;
	logic         injectMv, injectAv, injectPn, injectEr, injectCi, injectOf;
	int           failures = 0;
	int           checks   = 0;
	int           cycles   = 0;
	int           lat;

	always #4 clk_sys = ~clk_sys;

	pseudo_fault_counter pseudo_fault_counter_inst (.clk_sys(clk_sys), .rst_n(rst_n),
		.errRecoveryRst_n(errRecoveryRst_n), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
		.regWdata(regWdata), .regRdata(rdA), .regReadValid(rvA), .injectValid(injectValid),
		.injectKind(injectKind), .injectCe(injectCe), .injectMv(injectMv), .injectAv(injectAv),
		.injectPn(injectPn), .injectEr(injectEr), .injectCi(injectCi), .injectOf(injectOf));

	// The absent node only needs its read path; injection outputs stay open.
	pseudo_fault_counter #(.INJ_FEATURE(2'h0)) absent_inst (.clk_sys(clk_sys), .rst_n(rst_n),
		.errRecoveryRst_n(errRecoveryRst_n), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
		.regWdata(regWdata), .regRdata(rdB), .regReadValid(), .injectValid(), .injectKind(), .injectCe(),
		.injectMv(), .injectAv(), .injectPn(), .injectEr(), .injectCi(), .injectOf());

	pseudo_fault_counter #(.SUPPORT_MASK(64'h0000_0000_c000_1bff), .ALWAYS_ONE(RAO_POSSIBLE)) forced_inst (
		.clk_sys(clk_sys), .rst_n(rst_n), .errRecoveryRst_n(errRecoveryRst_n), .regWrite(regWrite),
		.regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(rdC), .regReadValid(),
		.injectValid(), .injectKind(), .injectCe(), .injectMv(), .injectAv(), .injectPn(), .injectEr(),
		.injectCi(), .injectOf());

	// ----------------------------------------------------------------
	// Bus and wait helpers
	// ----------------------------------------------------------------
	task automatic wr(input logic [11:0] a, input logic [63:0] d);
		@(posedge clk_sys);
		regWrite <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk_sys);
		regWrite <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [63:0] ea, input logic [63:0] eb, input logic [63:0] ec);
		@(posedge clk_sys);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRead <= 1'b0;
		#1;
		`CHK("readValid", 1'b1, rvA);
		`CHK("rdataMain", ea, rdA);
		`CHK("rdataAbsent", eb, rdB);
		`CHK("rdataForced", ec, rdC);
	endtask

	// Counts edges up to the injection pulse; returns lim when none came.
	task automatic wait_inj(input int lim, output int k);
		k = 0;
		do begin
			@(posedge clk_sys);
			#1;
			k++;
		end while (injectValid !== 1'b1 && k < lim);
	endtask

	task automatic end_sim();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		rd(CTRL_OFFSET, 64'h0, 64'h0, 64'h1800);
		wr(CDN_OFFSET, 64'hffff_ffff_1234_5678);
		rd(CDN_OFFSET, 64'h1234_5678, 64'h0, 64'h1234_5678);
		wr(CTRL_OFFSET, 64'hffff_ffff_7fff_ffff);
		rd(CTRL_OFFSET, 64'h4000_1fff, 64'h0, 64'h4000_1bff);
		rd(12'h818, 64'h0, 64'h0, 64'h0);
		$display("test regs done");
	endtask

	task automatic t_single();
		wr(CDN_OFFSET, 64'h3);
		wr(CTRL_OFFSET, 64'h8000_050c);
		wait_inj(40, lat);
		`CHK("latency", 3, lat);
		`CHK("kind", KIND_UEU, injectKind);
		`CHK("flags", 6'b001010, {injectMv, injectAv, injectPn, injectEr, injectCi, injectOf});
		wait_inj(30, lat);
		`CHK("stopped", 30, lat);
		wr(CTRL_OFFSET, 64'h8000_050c);
		wait_inj(40, lat);
		`CHK("reload", 3, lat);
		$display("test single done");
	endtask

	// Each expiry picks the most severe enabled type, and nothing at all when none is enabled.
	task automatic t_kinds();
		wr(CDN_OFFSET, 64'h1);
		wr(CTRL_OFFSET, 64'h8000_0036);
		wait_inj(10, lat);
		`CHK("ucLatency", 1, lat);
		`CHK("ucKind", KIND_UC, injectKind);
		`CHK("ucCe", 2'h0, injectCe);
		wr(CTRL_OFFSET, 64'h8000_0030);
		wait_inj(10, lat);
		`CHK("ueoKind", KIND_UEO, injectKind);
		wr(CTRL_OFFSET, 64'h8000_0020);
		wait_inj(10, lat);
		`CHK("deKind", KIND_DE, injectKind);
		wr(CTRL_OFFSET, 64'h8000_0000);
		wait_inj(10, lat);
		`CHK("noneQuiet", 10, lat);
		$display("test kinds done");
	endtask

	task automatic t_restart();
		wr(CDN_OFFSET, 64'h5);
		wr(CTRL_OFFSET, 64'hc000_1a81);
		wait_inj(40, lat);
		`CHK("latency", 5, lat);
		`CHK("kind", KIND_CE, injectKind);
		`CHK("ceField", 2'b10, injectCe);
		`CHK("flags", 6'b110101, {injectMv, injectAv, injectPn, injectEr, injectCi, injectOf});
		wait_inj(40, lat);
		`CHK("period", 5, lat);
		wr(CTRL_OFFSET, 64'h4000_1a81);
		wait_inj(30, lat);
		`CHK("disabled", 30, lat);
		$display("test restart done");
	endtask

	// Recovery reset must leave registers alone while a cold reset clears the enable.
	task automatic t_resets();
		wr(CTRL_OFFSET, 64'hc000_1a81);
		@(posedge clk_sys);
		errRecoveryRst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		errRecoveryRst_n <= 1'b1;
		rd(CTRL_OFFSET, 64'hc000_1a81, 64'h0, 64'hc000_1a81);
		rd(CDN_OFFSET, 64'h5, 64'h0, 64'h5);
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(CTRL_OFFSET, 64'h0, 64'h0, 64'h1800);
		$display("test resets done");
	endtask

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 2000) begin
			failures++;
			end_sim();
		end
	end

	initial begin
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_regs();
		t_single();
		t_kinds();
		t_restart();
		t_resets();
		end_sim();
	end
endmodule // pseudo_fault_injection_counter_bench
